/* File: core/phr_consts.svh */
`ifndef PHR_CONSTS_SVH
`define PHR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define PHR_CLK_MHZ          25

// ----------------------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PHR_IDX_CTRL         2'h0
`define PHR_IDX_SUPPLY       2'h1
`define PHR_IDX_STATUS       2'h2
`define PHR_IDX_WARN         2'h3
`define PHR_OFF_CTRL         32'h0000_0000
`define PHR_OFF_SUPPLY       32'h0000_0004
`define PHR_OFF_STATUS       32'h0000_0008
`define PHR_OFF_WARN         32'h0000_000c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PHR_CTRL_HIB_REQ     0
`define PHR_CTRL_CFG_LSB     1
`define PHR_CTRL_CFG_MSB     8
`define PHR_SUP_MSB          11
`define PHR_ST_SYS           0
`define PHR_ST_IO            1
`define PHR_ST_MS            2
`define PHR_ST_CORE          3
`define PHR_ST_TEMP          4
`define PHR_ST_WAKE_TMR      5
`define PHR_ST_WAKE_PB       6
`define PHR_ST_POR           7
`define PHR_ST_RAILS_LSB     8
`define PHR_ST_STATE_LSB     12
`define PHR_WARN_TEMP        0

// ----------------------------------------------------------------------------
// Reset values and field encodings
// ----------------------------------------------------------------------------
`define PHR_CTRL_RST         8'h00
`define PHR_SUP_RST          12'h040
`define PHR_STATUS_RST       8'h80
`define PHR_SUPPLY_MONITOR_OUTPUT_LAST        3'h5
`define PHR_VP_RSVD          2'h3
`define PHR_WAKE_INF         3'h7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PHR_DEFAULT_FREQ_MS  6
`define PHR_WAKE_TICK_MS     125
`define PHR_RST_BASE_MS      1
`define PHR_BLANK_NS         200
`define PHR_DEFAULT_FREQ_CYC (`PHR_DEFAULT_FREQ_MS * `PHR_CLK_MHZ * 1000)
`define PHR_WAKE_TICK_CYC    (`PHR_WAKE_TICK_MS * `PHR_CLK_MHZ * 1000)
`define PHR_RST_BASE_CYC     (`PHR_RST_BASE_MS * `PHR_CLK_MHZ * 1000)
`define PHR_BLANK_CYC        ((`PHR_BLANK_NS * `PHR_CLK_MHZ + 999) / 1000)
`define PHR_SEQ_STEP_CYC     4

`endif

/* File: core/phr_pkg.sv */
package phr_pkg;

    typedef enum logic [2:0] {
        PHR_SAFE, PHR_DEFAULT, PHR_SYSREG, PHR_SEQ, PHR_PORWAIT, PHR_RUN, PHR_HIB
    } phr_state_t;

    // Supply rails with a power-good monitor, sys in bit 0
    typedef struct packed {
        logic core;
        logic ms;
        logic io;
        logic sys;
    } phr_rails_t;

    typedef struct packed {
        logic core;
        logic ms;
        logic io;
        logic flash;
        logic sys;
    } phr_reg_en_t;

    typedef struct packed {
        logic       safe;
        logic       high;
        logic [2:0] sel;
    } phr_freq_t;

    // CTRL bits 8:1
    typedef struct packed {
        logic [1:0] rstDurSel;
        logic       tempWarnMask;
        logic       tempFaultMask;
        logic [2:0] wakeSel;
        logic       pbEn;
    } phr_ctrl_t;

    // SUPPLY bits 11:0
    typedef struct packed {
        logic       sscDisable;
        logic [2:0] freqSel;
        logic       freqHigh;
        logic [1:0] vpSel;
        logic [1:0] threfSel;
        logic [2:0] vmonSel;
    } phr_supply_t;

    typedef struct packed {
        phr_state_t  st;
        logic [31:0] cnt;
        logic [6:0]  tick;
        logic [2:0]  seqIdx;
        phr_ctrl_t   ctrl;
        phr_supply_t sup;
        logic [7:0]  status;
        logic        warn;
        logic        pbPrev;
        logic        warnPrev;
        logic [7:0]  blank;
        logic        hibPbEn;
        logic [2:0]  hibWake;
        logic        aWr;
        logic [1:0]  aIdx;
        logic [31:0] rdata;
    } phr_regs_t;

endpackage

/* File: core/phr_power_manager.sv */
`timescale 1ns/100ps
`include "phr_consts.svh"

module phr_power_manager
    import phr_pkg::*;
#(
    parameter int unsigned DEFAULT_FREQ_CYC = `PHR_DEFAULT_FREQ_CYC,
    parameter int unsigned WAKE_TICK_CYC    = `PHR_WAKE_TICK_CYC,
    parameter int unsigned RST_BASE_CYC     = `PHR_RST_BASE_CYC,
    parameter int unsigned SEQ_STEP_CYC     = `PHR_SEQ_STEP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Analog status
    input  wire logic        mainSupplyAboveUvlo,
    input  wire logic        sysSupplyAbove4v,
    input  wire phr_rails_t  railGood,
    input  wire logic        tempFault170,
    input  wire logic        tempWarn140,
    input  wire logic        push_button_input,
    input  wire logic        switchTurnOn,
    input  wire logic        current_sense_input,
    // Controls
    output logic             mcuResetN,
    output logic             tempWarnIrq,
    output logic             hibernateActive,
    output phr_reg_en_t      regEn,
    output logic             sscEnable,
    output phr_freq_t        sscFreq,
    output logic [1:0]       vpTarget,
    output logic [2:0]       supply_monitor_output,
    output logic [1:0]       threshold_reference,
    output logic             currentLimitTrip
);

    if (DEFAULT_FREQ_CYC < 1 || WAKE_TICK_CYC < 1 || RST_BASE_CYC < 1 || SEQ_STEP_CYC < 1)
        $error("phr_power_manager: timing counts must be at least one");
    if (`PHR_BLANK_CYC > 255)
        $error("phr_power_manager: blanking count exceeds counter");

    localparam int unsigned BLANK_CYC = `PHR_BLANK_CYC;

    phr_regs_t r_r;
    phr_regs_t r_nxt;

    logic        pbEvt;
    logic        warnEvt;
    logic        hibReq;
    logic        allGood;
    logic [7:0]  stSet;
    logic [7:0]  stClr;
    logic        warnClr;
    logic [31:0] rstDurCyc;
    logic [31:0] rdVal;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        r_nxt     = r_r;
        r_nxt.aWr = 1'b0;
        pbEvt     = push_button_input & ~r_r.pbPrev;
        warnEvt   = tempWarn140 & ~r_r.warnPrev;
        r_nxt.pbPrev   = push_button_input;
        r_nxt.warnPrev = tempWarn140;
        hibReq    = 1'b0;
        stSet     = 8'h00;
        stClr     = 8'h00;
        warnClr   = 1'b0;
        allGood   = &railGood;
        rstDurCyc = RST_BASE_CYC << r_r.ctrl.rstDurSel;
        rdVal     = 32'h0000_0000;

        // Register write data phase
        if (r_r.aWr) begin
            case (r_r.aIdx)
                `PHR_IDX_CTRL: begin
                    r_nxt.ctrl = phr_ctrl_t'(hwdata[`PHR_CTRL_CFG_MSB:`PHR_CTRL_CFG_LSB]);
                    hibReq     = hwdata[`PHR_CTRL_HIB_REQ];
                end
                `PHR_IDX_SUPPLY: begin
                    r_nxt.sup = phr_supply_t'(hwdata[`PHR_SUP_MSB:0]);
                    if (r_nxt.sup.vmonSel > `PHR_SUPPLY_MONITOR_OUTPUT_LAST)
                        r_nxt.sup.vmonSel = r_r.sup.vmonSel;
                    if (r_nxt.sup.vpSel == `PHR_VP_RSVD)
                        r_nxt.sup.vpSel = r_r.sup.vpSel;
                end
                `PHR_IDX_STATUS: begin
                    stClr = hwdata[7:0];
                end
                `PHR_IDX_WARN: begin
                    warnClr = hwdata[`PHR_WARN_TEMP];
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Sequencer
        // ------------------------------------------------------------------
        r_nxt.cnt = r_r.cnt + 32'h1;
        case (r_r.st)
            PHR_SAFE: begin
                r_nxt.cnt = 32'h0;
                if (mainSupplyAboveUvlo)
                    r_nxt.st = PHR_DEFAULT;
            end
            PHR_DEFAULT: begin
                if (r_r.cnt >= DEFAULT_FREQ_CYC - 1) begin
                    r_nxt.st  = PHR_SYSREG;
                    r_nxt.cnt = 32'h0;
                end
            end
            PHR_SYSREG: begin
                r_nxt.cnt    = 32'h0;
                r_nxt.seqIdx = 3'h0;
                if (sysSupplyAbove4v)
                    r_nxt.st = PHR_SEQ;
            end
            PHR_SEQ: begin
                if (r_r.cnt >= SEQ_STEP_CYC - 1) begin
                    r_nxt.cnt    = 32'h0;
                    r_nxt.seqIdx = r_r.seqIdx + 3'h1;
                    if (r_r.seqIdx == 3'h3)
                        r_nxt.st = PHR_PORWAIT;
                end
            end
            PHR_PORWAIT: begin
                if (!allGood)
                    r_nxt.cnt = 32'h0;
                else if (r_r.cnt >= rstDurCyc - 1)
                    r_nxt.st = PHR_RUN;
            end
            PHR_RUN: begin
                r_nxt.cnt = 32'h0;
                if (!allGood) begin
                    stSet[3:0] = ~railGood;
                    r_nxt.st   = PHR_PORWAIT;
                end else if (tempFault170 && !r_r.ctrl.tempFaultMask) begin
                    stSet[`PHR_ST_TEMP] = 1'b1;
                    r_nxt.st            = PHR_PORWAIT;
                end else if (hibReq || (pbEvt && r_r.ctrl.pbEn)) begin
                    r_nxt.st      = PHR_HIB;
                    r_nxt.tick    = 7'h0;
                    r_nxt.hibPbEn = r_r.ctrl.pbEn;
                    r_nxt.hibWake = r_r.ctrl.wakeSel;
                    r_nxt.ctrl    = phr_ctrl_t'(`PHR_CTRL_RST);
                    r_nxt.sup     = phr_supply_t'(`PHR_SUP_RST);
                    r_nxt.warn    = 1'b0;
                    warnClr       = 1'b1;
                end
            end
            PHR_HIB: begin
                if (r_r.cnt >= WAKE_TICK_CYC - 1) begin
                    r_nxt.cnt  = 32'h0;
                    r_nxt.tick = r_r.tick + 7'h1;
                end
                if (r_r.hibWake != `PHR_WAKE_INF
                    && r_r.tick == (7'h1 << r_r.hibWake)) begin
                    stSet[`PHR_ST_WAKE_TMR] = 1'b1;
                    r_nxt.st                = PHR_SAFE;
                end else if (r_r.hibPbEn && pbEvt) begin
                    stSet[`PHR_ST_WAKE_PB] = 1'b1;
                    r_nxt.st               = PHR_SAFE;
                end
                if (r_nxt.st == PHR_SAFE)
                    r_nxt.cnt = 32'h0;
            end
            default: begin
                r_nxt.st = PHR_SAFE;
            end
        endcase

        r_nxt.status = (r_r.status & ~stClr) | stSet;
        r_nxt.warn = (r_r.warn & ~warnClr) | (warnEvt & (r_r.st != PHR_HIB));

        if (switchTurnOn)
            r_nxt.blank = 8'(BLANK_CYC);
        else if (r_r.blank != 8'h00)
            r_nxt.blank = r_r.blank - 8'h1;

        // ------------------------------------------------------------------
        // AHB address phase
        // ------------------------------------------------------------------
        case (haddr[3:2])
            `PHR_IDX_CTRL:   rdVal = {23'h0, r_r.ctrl, 1'b0};
            `PHR_IDX_SUPPLY: rdVal = {20'h0, r_r.sup};
            `PHR_IDX_STATUS: rdVal = {17'h0, r_r.st, railGood, r_r.status};
            `PHR_IDX_WARN:   rdVal = {31'h0, r_r.warn};
            default:         rdVal = 32'h0000_0000;
        endcase
        if (haddr[31:4] != 28'h0)
            rdVal = 32'h0000_0000;
        if (hsel && htrans[1] && hready) begin
            r_nxt.aWr   = hwrite && (haddr[31:4] == 28'h0);
            r_nxt.aIdx  = haddr[3:2];
            r_nxt.rdata = rdVal;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r_r        <= '0;
            r_r.st     <= PHR_SAFE;
            r_r.ctrl   <= phr_ctrl_t'(`PHR_CTRL_RST);
            r_r.sup    <= phr_supply_t'(`PHR_SUP_RST);
            r_r.status <= `PHR_STATUS_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r_r.rdata;

    assign mcuResetN       = (r_r.st == PHR_RUN);
    assign hibernateActive = (r_r.st == PHR_HIB);
    assign tempWarnIrq     = r_r.warn & ~r_r.ctrl.tempWarnMask;

    assign sscEnable   = (r_r.st != PHR_HIB) && !r_r.sup.sscDisable;
    assign regEn.sys   = (r_r.st == PHR_SYSREG) || (r_r.st == PHR_SEQ)
                         || (r_r.st == PHR_PORWAIT) || (r_r.st == PHR_RUN);
    assign regEn.flash = regEn.sys && ((r_r.st != PHR_SEQ) && (r_r.st != PHR_SYSREG)
                         || (r_r.st == PHR_SEQ && r_r.seqIdx >= 3'h0));
    assign regEn.io    = regEn.sys && ((r_r.st != PHR_SEQ) && (r_r.st != PHR_SYSREG)
                         || (r_r.st == PHR_SEQ && r_r.seqIdx >= 3'h1));
    assign regEn.ms    = regEn.sys && ((r_r.st != PHR_SEQ) && (r_r.st != PHR_SYSREG)
                         || (r_r.st == PHR_SEQ && r_r.seqIdx >= 3'h2));
    assign regEn.core  = regEn.sys && ((r_r.st != PHR_SEQ) && (r_r.st != PHR_SYSREG)
                         || (r_r.st == PHR_SEQ && r_r.seqIdx >= 3'h3));

    assign sscFreq.safe = (r_r.st == PHR_SAFE);
    assign sscFreq.high = r_r.sup.freqHigh;
    assign sscFreq.sel  = r_r.sup.freqSel;

    assign vpTarget              = r_r.sup.vpSel;
    assign supply_monitor_output = r_r.sup.vmonSel;
    assign threshold_reference   = r_r.sup.threfSel;
    assign currentLimitTrip      = current_sense_input && (r_r.blank == 8'h00)
                                   && !switchTurnOn;

endmodule // phr_power_manager

/* File: dv/phr_supply_model.sv */
`timescale 1ns/100ps
// ----
// Rails that follow the regulator enables, with injectable drops
// ----
module phr_supply_model
    import phr_pkg::*;
#(
    parameter int RISE = 3
) (
    input  wire logic        core_clk,
    input  wire logic        sscEnable,
    input  wire phr_reg_en_t regEn,
    input  wire logic [3:0]  railDrop,
    output logic             mainUp,
    output logic             sysUp,
    output phr_rails_t       good
);
    int cnt;

    initial begin
        cnt = 0;
        mainUp = 1'b0;
        sysUp = 1'b0;
        good = '0;
    end

    // Main supply needs some cycles of switching before it clears lockout
    always @(posedge core_clk) begin
        cnt <= sscEnable ? ((cnt < RISE) ? cnt + 1 : cnt) : 0;
        mainUp <= sscEnable && (cnt >= RISE);
        sysUp <= regEn.sys;
        good <= {regEn.core, regEn.ms, regEn.io, regEn.sys} & ~railDrop;
    end
endmodule // phr_supply_model

/* File: dv/phr_pm_props.sv */
`timescale 1ns/100ps
module phr_pm_props
    import phr_pkg::*;
#(
    parameter int unsigned DEFAULT_FREQ_CYC = 20,
    parameter int unsigned RST_BASE_CYC     = 8
) (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        mainSupplyAboveUvlo,
    input wire logic        sysSupplyAbove4v,
    input wire phr_rails_t  railGood,
    input wire logic        switchTurnOn,
    input wire logic        current_sense_input,
    input wire logic        mcuResetN,
    input wire logic        hibernateActive,
    input wire phr_reg_en_t regEn,
    input wire logic        sscEnable,
    input wire phr_freq_t   sscFreq,
    input wire logic [1:0]  vpTarget,
    input wire logic [2:0]  supply_monitor_output,
    input wire logic        currentLimitTrip
);
    logic [31:0] dflCnt_r;
    logic [31:0] goodCnt_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Cycles at default frequency, and cycles of all rails good
    always_ff @(posedge core_clk) begin
        if (!rstn || sscFreq.safe || regEn != '0 || hibernateActive)
            dflCnt_r <= '0;
        else
            dflCnt_r <= dflCnt_r + 32'h1;
        if (!rstn || railGood != 4'hf)
            goodCnt_r <= '0;
        else if (goodCnt_r != 32'hffff_ffff)
            goodCnt_r <= goodCnt_r + 32'h1;
    end

    property p_hib_off;
        hibernateActive |-> regEn == '0 && !sscEnable && !mcuResetN;
    endproperty
    a_hib_off: assert property (p_hib_off) else $error("hibernate outputs on");
    property p_fault_rst;
        mcuResetN && railGood != 4'hf |=> !mcuResetN;
    endproperty
    a_fault_rst: assert property (p_fault_rst) else $error("no reset on drop");
    property p_rst_hold;
        !mcuResetN && railGood != 4'hf |=> !mcuResetN;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
    property p_rst_len;
        $rose(mcuResetN) |-> goodCnt_r >= RST_BASE_CYC;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset too short");
    property p_dfl_len;
        $rose(regEn.sys) |-> dflCnt_r >= DEFAULT_FREQ_CYC;
    endproperty
    a_dfl_len: assert property (p_dfl_len) else $error("default phase short");
    property p_safe_hold;
        sscFreq.safe && !mainSupplyAboveUvlo |=> sscFreq.safe;
    endproperty
    a_safe_hold: assert property (p_safe_hold) else $error("safe left early");
    property p_seq;
        ($rose(regEn.flash) |-> $past(sysSupplyAbove4v))
            and ($rose(regEn.core) |-> $past(regEn.ms) && regEn.io && regEn.flash);
    endproperty
    a_seq: assert property (p_seq) else $error("regulator order");
    property p_wake;
        $fell(hibernateActive) |-> !mcuResetN && sscFreq.safe && sscEnable;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not start-up");
    property p_blank;
        switchTurnOn |-> (!currentLimitTrip) [*5];
    endproperty
    a_blank: assert property (p_blank) else $error("trip in blanking");
    property p_live;
        switchTurnOn ##1 (!switchTurnOn) [*5] ##1 (current_sense_input && !switchTurnOn)
            |-> currentLimitTrip;
    endproperty
    a_live: assert property (p_live) else $error("trip missed");
    property p_sel;
        supply_monitor_output <= 3'h5 && vpTarget != 2'h3;
    endproperty
    a_sel: assert property (p_sel) else $error("bad select");
endmodule // phr_pm_props

bind phr_power_manager phr_pm_props #(
    .DEFAULT_FREQ_CYC(DEFAULT_FREQ_CYC), .RST_BASE_CYC(RST_BASE_CYC)
) u_props (
    .core_clk(core_clk), .rstn(rstn), .mainSupplyAboveUvlo(mainSupplyAboveUvlo),
    .sysSupplyAbove4v(sysSupplyAbove4v), .railGood(railGood), .switchTurnOn(switchTurnOn),
    .current_sense_input(current_sense_input), .mcuResetN(mcuResetN),
    .hibernateActive(hibernateActive), .regEn(regEn), .sscEnable(sscEnable),
    .sscFreq(sscFreq), .vpTarget(vpTarget), .supply_monitor_output(supply_monitor_output),
    .currentLimitTrip(currentLimitTrip)
);

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`include "phr_consts.svh"
module testbench;
    import phr_pkg::*;
    logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, mainUp, sysUp, tempFault170;
    logic tempWarn140, push_button_input, switchTurnOn, current_sense_input, mcuResetN;
    logic tempWarnIrq, hibernateActive, sscEnable, currentLimitTrip;
    logic [1:0] htrans, vpTarget, threshold_reference;
    logic [2:0] hsize, supply_monitor_output;
    logic [3:0] railDrop;
    logic [31:0] haddr, hwdata, hrdata;
    phr_rails_t good;
    phr_reg_en_t regEn;
    phr_freq_t sscFreq;
    int errTotal = 0;
    int cmpCount = 0;

    phr_power_manager #(.DEFAULT_FREQ_CYC(20), .WAKE_TICK_CYC(10), .RST_BASE_CYC(8),
        .SEQ_STEP_CYC(4)) uut (
        .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mainSupplyAboveUvlo(mainUp),
        .sysSupplyAbove4v(sysUp), .railGood(good), .tempFault170(tempFault170),
        .tempWarn140(tempWarn140), .push_button_input(push_button_input),
        .switchTurnOn(switchTurnOn), .current_sense_input(current_sense_input),
        .mcuResetN(mcuResetN), .tempWarnIrq(tempWarnIrq), .hibernateActive(hibernateActive),
        .regEn(regEn), .sscEnable(sscEnable), .sscFreq(sscFreq), .vpTarget(vpTarget),
        .supply_monitor_output(supply_monitor_output),
        .threshold_reference(threshold_reference), .currentLimitTrip(currentLimitTrip));

    phr_supply_model u_sup (.core_clk(core_clk), .sscEnable(sscEnable), .regEn(regEn),
        .railDrop(railDrop), .mainUp(mainUp), .sysUp(sysUp), .good(good));

    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end

    // ----
    // Bench tasks
    // ----
    task automatic print_verdict();
        if (errTotal == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errTotal++;
                $display("ERROR %0t: bus ready timed out", $time);
                print_verdict();
            end
            @(posedge core_clk);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask

    // Write, then one idle cycle so a read-back sees the new value
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        @(posedge core_clk);
    endtask

    task automatic rdc(input logic [31:0] a, exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, exp);
        check(32'(hresp), 0);
    endtask

    task automatic wait_pin(input bit hib, input logic lvl);
        int n;
        n = 0;
        while ((hib ? hibernateActive : mcuResetN) !== lvl) begin
            @(posedge core_clk);
            n++;
            if (n > 3000) begin
                errTotal++;
                $display("ERROR %0t: wait timed out", $time);
                print_verdict();
            end
        end
    endtask

    task automatic pulse_button();
        push_button_input <= 1'b1;
        @(posedge core_clk);
        push_button_input <= 1'b0;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_boot();
        check(32'(mcuResetN), 0);
        check(32'(sscFreq.safe), 1);
        check(32'(vpTarget), 2);
        wait_pin(0, 1'b1);
        check(32'(regEn), 32'h1f);
        rdc(`PHR_OFF_STATUS, 32'h5f80);
        rdc(32'h10, 32'h0);
        wr(`PHR_OFF_STATUS, 32'hff);
        rdc(`PHR_OFF_STATUS, 32'h5f00);
    endtask

    task automatic t_supply();
        for (int i = 0; i < 16; i++) begin
            wr(`PHR_OFF_SUPPLY, 32'((i << 7) | ((i % 3) << 5) | ((i % 4) << 3) | (i % 6)));
            check(32'(supply_monitor_output), i % 6);
            check(32'(threshold_reference), i % 4);
            check(32'(vpTarget), i % 3);
            check(32'(sscFreq), ((i % 2) << 3) | (i / 2));
        end
        wr(`PHR_OFF_SUPPLY, 32'h86e);
        check(32'(sscEnable), 0);
        rdc(`PHR_OFF_SUPPLY, 32'h80b);
    endtask

    task automatic t_blank();
        current_sense_input <= 1'b1;
        switchTurnOn <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            @(negedge core_clk);
            check(32'(currentLimitTrip), k == 6);
            @(posedge core_clk);
            switchTurnOn <= 1'b0;
        end
        current_sense_input <= 1'b0;
    endtask

    task automatic t_fault();
        railDrop <= 4'b0010;
        repeat (12) @(posedge core_clk);
        check(32'(mcuResetN), 0);
        railDrop <= 4'b0000;
        wait_pin(0, 1'b1);
        rdc(`PHR_OFF_STATUS, 32'h5f02);
        wr(`PHR_OFF_STATUS, 32'hff);
    endtask

    task automatic t_temp();
        tempWarn140 <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'({tempWarnIrq, mcuResetN}), 3);
        wr(`PHR_OFF_CTRL, 32'h40);
        check(32'(tempWarnIrq), 0);
        wr(`PHR_OFF_WARN, 32'h1);
        wr(`PHR_OFF_CTRL, 32'h0);
        rdc(`PHR_OFF_WARN, 32'h0);
        tempWarn140 <= 1'b0;
        wr(`PHR_OFF_CTRL, 32'h20);
        tempFault170 <= 1'b1;
        repeat (10) @(posedge core_clk);
        check(32'(mcuResetN), 1);
        wr(`PHR_OFF_CTRL, 32'h0);
        wait_pin(0, 1'b0);
        tempFault170 <= 1'b0;
        wait_pin(0, 1'b1);
        rdc(`PHR_OFF_STATUS, 32'h5f10);
        wr(`PHR_OFF_STATUS, 32'hff);
    endtask

    task automatic t_hib();
        wr(`PHR_OFF_SUPPLY, 32'h0a5);
        wr(`PHR_OFF_CTRL, 32'h1);
        wait_pin(1, 1'b1);
        check(32'({regEn, sscEnable}), 0);
        wait_pin(1, 1'b0);
        wait_pin(0, 1'b1);
        rdc(`PHR_OFF_STATUS, 32'h5f20);
        rdc(`PHR_OFF_SUPPLY, 32'h040);
        wr(`PHR_OFF_STATUS, 32'hff);
        wr(`PHR_OFF_CTRL, 32'h1e);
        pulse_button();
        wait_pin(1, 1'b1);
        repeat (100) @(posedge core_clk);
        check(32'(hibernateActive), 1);
        pulse_button();
        wait_pin(1, 1'b0);
        wait_pin(0, 1'b1);
        rdc(`PHR_OFF_STATUS, 32'h5f40);
    endtask

    initial begin
        rstn = 0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {tempFault170, tempWarn140, push_button_input, switchTurnOn} = '0;
        current_sense_input = 0;
        railDrop = '0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        t_boot();
        t_supply();
        t_blank();
        t_fault();
        t_temp();
        t_hib();
        print_verdict();
    end
endmodule // testbench
